/* src/tweep_slave.sv */
// Two-wire EEPROM slave: bus protocol, page buffer, program timer and array
`include "tweep_defines.svh"
module tweep_slave
    import tweep_pkg::*;
#(
    parameter int ADDR_W    = `TWE_ADDR_W,
    parameter int PAGE_W    = `TWE_PAGE_W,
    parameter int WR_CYCLES = `TWE_TWR_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    input  wire logic select_pin_high,
    input  wire logic select_pin_mid,
    input  wire logic select_pin_low,
    input  wire logic wp_i,
    output logic      prog_busy
);
    localparam int PAGE_N = 1 << PAGE_W;
    localparam int MEM_N  = 1 << ADDR_W;
    localparam int PCNT_W = $clog2(WR_CYCLES + 1);
    localparam int ROW_W  = ADDR_W - PAGE_W;

    logic [5:0]        sync1_r;
    logic [5:0]        sync2_r;
    logic [1:0]        prev_r;
    tweep_state_t      state_r;
    logic [3:0]        cnt_r;
    logic [7:0]        shreg_r;
    logic [7:0]        rd_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ROW_W-1:0]  wpage_r;
    logic [PAGE_W-1:0] woff_r;
    logic [5:0]        ahi_r;
    logic [PAGE_N-1:0] vld_r;
    logic              oe_r;
    logic              busy_r;
    logic [PCNT_W-1:0] pcnt_r;
    logic [7:0]        mem [MEM_N];
    logic [7:0]        pbuf [PAGE_N];

    logic scl_s, sda_s, wp_s, scl_p, sda_p;
    logic [2:0] sel_s;
    logic rise_ev, fall_ev, start_ev, stop_ev;
    logic byte_done, dev_match, wr_byte, rd_load, prog_go, prog_wr;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Pins are asynchronous: two stages before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 6'h3f;
            sync2_r <= 6'h3f;
            prev_r  <= 2'h3;
        end else begin
            sync1_r <= {select_pin_high, select_pin_mid, select_pin_low, wp_i, sda_i, scl_i};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r[1:0];
        end
    end

    assign scl_s = sync2_r[0];
    assign sda_s = sync2_r[1];
    assign wp_s  = sync2_r[2];
    assign sel_s = sync2_r[5:3];
    assign scl_p = prev_r[0];
    assign sda_p = prev_r[1];

    assign start_ev = scl_s && scl_p && sda_p && !sda_s;
    assign stop_ev  = scl_s && scl_p && !sda_p && sda_s;
    assign rise_ev  = scl_s && !scl_p;
    assign fall_ev  = !scl_s && scl_p;

    assign byte_done = fall_ev && cnt_r == `TWE_BIT_LAST && state_r != TW_RDAT;
    assign dev_match = shreg_r[`TWE_TYPE_HI:`TWE_TYPE_LO] == `TWE_DEV_TYPE
                    && shreg_r[`TWE_SEL_HI:`TWE_SEL_LO] == sel_s && !busy_r;
    assign wr_byte   = byte_done && state_r == TW_WDAT;
    assign rd_load   = fall_ev && state_r == TW_RDAT && cnt_r == 4'h0;
    // Program only on stop, with data, unprotected
    assign prog_go   = stop_ev && state_r == TW_WDAT && |vld_r && !wp_s && !busy_r;
    assign prog_wr   = busy_r && pcnt_r < PCNT_W'(PAGE_N) && vld_r[pcnt_r[PAGE_W-1:0]];

    // Protocol engine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= TW_IDLE;
            cnt_r   <= 4'h0;
            shreg_r <= 8'h00;
            rd_r    <= 8'h00;
            addr_r  <= `TWE_ADDR_RST;
            wpage_r <= '0;
            woff_r  <= '0;
            ahi_r   <= 6'h00;
            vld_r   <= '0;
            oe_r    <= 1'b0;
        end else if (busy_r) begin
            state_r <= TW_IDLE;
            oe_r    <= 1'b0;
        end else if (start_ev) begin
            state_r <= TW_DEV;
            cnt_r   <= 4'h0;
            oe_r    <= 1'b0;
        end else if (stop_ev) begin
            state_r <= TW_IDLE;
            oe_r    <= 1'b0;
        end else if (state_r != TW_IDLE) begin
            if (rise_ev) begin
                if (cnt_r == `TWE_BIT_LAST) begin
                    cnt_r <= 4'h0;
                    if (state_r == TW_RDAT && sda_s)
                        state_r <= TW_WAITP;
                end else begin
                    cnt_r   <= cnt_r + 4'h1;
                    shreg_r <= {shreg_r[6:0], sda_s};
                end
            end else if (state_r == TW_RDAT && fall_ev) begin
                if (rd_load) begin
                    // Send byte at counter, counter moves on
                    rd_r   <= {mem[addr_r][6:0], 1'b0};
                    oe_r   <= !mem[addr_r][7];
                    // Counter wraps over the whole array
                    addr_r <= addr_r + ADDR_W'(1);
                end else if (cnt_r == `TWE_BIT_LAST) begin
                    oe_r <= 1'b0;
                end else begin
                    oe_r <= !rd_r[7];
                    rd_r <= {rd_r[6:0], 1'b0};
                end
            end else if (byte_done) begin
                // Ack driven through the ninth clock
                oe_r <= 1'b1;
                unique case (state_r)
                    TW_DEV: begin
                        if (!dev_match) begin
                            oe_r    <= 1'b0;
                            state_r <= TW_IDLE;
                        end else if (shreg_r[`TWE_DIR_BIT]) begin
                            state_r <= TW_RDAT;
                        end else begin
                            state_r <= TW_AHI;
                        end
                    end
                    TW_AHI: begin
                        ahi_r   <= shreg_r[5:0];
                        state_r <= TW_ALO;
                    end
                    TW_ALO: begin
                        addr_r  <= {ahi_r, shreg_r};
                        {wpage_r, woff_r} <= {ahi_r, shreg_r};
                        vld_r   <= '0;
                        state_r <= TW_WDAT;
                    end
                    TW_WDAT: begin
                        vld_r[woff_r] <= 1'b1;
                        woff_r        <= woff_r + PAGE_W'(1);
                        addr_r        <= {wpage_r, woff_r + PAGE_W'(1)};
                    end
                    default: begin
                        oe_r <= 1'b0;
                    end
                endcase
            end else if (fall_ev) begin
                oe_r <= 1'b0;
            end
        end
    end

    a_hi_dropped: assert property (byte_done && state_r == TW_AHI && !busy_r
                                   |=> ahi_r == $past(shreg_r[5:0]))
        else $error("upper address byte not kept");
    a_lo_to_data: assert property (byte_done && state_r == TW_ALO && !busy_r
                                   |=> state_r == TW_WDAT && addr_r == {$past(ahi_r), $past(shreg_r)})
        else $error("word address not loaded");
    a_read_nack: assert property (rise_ev && state_r == TW_RDAT
                                  && cnt_r == `TWE_BIT_LAST && sda_s |=> state_r == TW_WAITP)
        else $error("read went on after nack");
    a_read_more: assert property (rise_ev && state_r == TW_RDAT
                                  && cnt_r == `TWE_BIT_LAST && !sda_s |=> state_r == TW_RDAT)
        else $error("read stopped after ack");
    a_ack_bytes: assert property (byte_done && !busy_r && state_r inside {TW_AHI, TW_ALO, TW_WDAT}
                                  |=> oe_r ##1 sda_oe)
        else $error("written byte not acknowledged");
    a_ack_release: assert property (fall_ev && cnt_r == 4'h0 && !busy_r
                                    && state_r inside {TW_AHI, TW_ALO, TW_WDAT} |=> !oe_r)
        else $error("acknowledge held too long");
    a_wrap_read: assert property (rd_load && addr_r == {ADDR_W{1'b1}}
                                  |=> addr_r == ADDR_W'(0))
        else $error("read counter did not wrap");
    a_stop_idle: assert property (stop_ev && !busy_r |=> state_r == TW_IDLE && !oe_r)
        else $error("stop did not reach standby");
    a_wp_ack: assert property (byte_done && wp_s && !busy_r
                               && state_r inside {TW_AHI, TW_ALO, TW_WDAT} |=> oe_r)
        else $error("protected write not acknowledged");

    // Page buffer and array; the buffer decouples bus bytes from the slow program
    always_ff @(posedge clk) begin
        if (wr_byte)
            pbuf[woff_r] <= shreg_r;
        if (prog_wr)
            mem[{wpage_r, pcnt_r[PAGE_W-1:0]}] <= pbuf[pcnt_r[PAGE_W-1:0]];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            pcnt_r <= '0;
        end else if (prog_go) begin
            busy_r <= 1'b1;
            pcnt_r <= '0;
        end else if (busy_r) begin
            pcnt_r <= pcnt_r + PCNT_W'(1);
            // Free again only when the count ends
            if (pcnt_r == PCNT_W'(WR_CYCLES - 1))
                busy_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_o     <= 1'b0;
            sda_oe    <= 1'b0;
            prog_busy <= 1'b0;
        end else begin
            sda_o     <= 1'b0;
            sda_oe    <= oe_r;
            prog_busy <= busy_r;
        end
    end

    a_out_reg: assert property (sda_oe == $past(oe_r))
        else $error("pin enable out of step");

    // Helper: cycles spent so far in the current busy period; holds the period length for the first idle cycle, then zero
    logic [PCNT_W-1:0] blen_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            blen_r <= '0;
        else if (busy_r)
            blen_r <= blen_r + PCNT_W'(1);
        else
            blen_r <= '0;
    end

    a_busy_deaf: assert property (busy_r && $past(busy_r) |-> !oe_r && state_r == TW_IDLE)
        else $error("answer while programming");
    a_prog_len: assert property ($fell(busy_r) |-> blen_r == PCNT_W'(WR_CYCLES))
        else $error("program cycle length wrong");
    a_busy_bound: assert property (blen_r <= PCNT_W'(WR_CYCLES))
        else $error("program cycle too long");
    a_wp_block: assert property (stop_ev && wp_s && !busy_r |=> !busy_r)
        else $error("program started under protect");
    a_prog_start: assert property (stop_ev && state_r == TW_WDAT && |vld_r && !wp_s && !busy_r
                                   |=> busy_r ##1 prog_busy)
        else $error("stop did not start program");
    a_ack_match: assert property (byte_done && state_r == TW_DEV && dev_match
                                  |=> oe_r ##[1:2] sda_oe)
        else $error("matching address not acknowledged");
    a_nomatch_idle: assert property (byte_done && state_r == TW_DEV && !dev_match
                                     |=> !oe_r && state_r == TW_IDLE)
        else $error("mismatch not ignored");
    a_dir_read: assert property (byte_done && state_r == TW_DEV && dev_match && shreg_r[`TWE_DIR_BIT]
                                 |=> state_r == TW_RDAT)
        else $error("read direction not taken");
    a_page_fixed: assert property (wr_byte |=> addr_r[ADDR_W-1:PAGE_W] == $past(wpage_r)
                                   && addr_r[PAGE_W-1:0] == PAGE_W'($past(woff_r) + 1))
        else $error("write address left the page");
    a_read_inc: assert property (rd_load && !busy_r && !start_ev && !stop_ev
                                 |=> addr_r == ADDR_W'($past(addr_r) + 1))
        else $error("read counter did not advance");
    a_start_dev: assert property (start_ev && !busy_r |=> state_r == TW_DEV && cnt_r == 4'h0)
        else $error("start did not restart reception");
endmodule // tweep_slave

/* src/tweep_defines.svh */
// Constants, field positions and timing counts of the two-wire EEPROM slave
`ifndef TWEEP_DEFINES_SVH
`define TWEEP_DEFINES_SVH
`define TWE_DEV_TYPE   4'ha
`define TWE_TYPE_HI    7
`define TWE_TYPE_LO    4
`define TWE_SEL_HI     3
`define TWE_SEL_LO     1
`define TWE_DIR_BIT    0
`define TWE_ADDR_W     14
`define TWE_PAGE_W     6
`define TWE_BIT_LAST   4'h8
`define TWE_ADDR_RST   14'h0000
`define TWE_CLK_NS     4
`define TWE_NS_PER_MS  1000000
`define TWE_TWR_MS     5
`define TWE_TWR_CYC    (`TWE_TWR_MS * `TWE_NS_PER_MS / `TWE_CLK_NS)
`endif

/* src/tweep_pkg.sv */
// Types shared by the two-wire EEPROM slave
package tweep_pkg;
    typedef enum logic [2:0] {
        TW_IDLE, TW_DEV, TW_AHI, TW_ALO, TW_WDAT, TW_RDAT, TW_WAITP
    } tweep_state_t;
endpackage

/* tb/tweep_master.sv */
// Two-wire bus master model: start, stop and byte transfers
module tweep_master (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic q();
        repeat (5) @(negedge clk);
    endtask
    task automatic cond(input logic s);
        sda_low = ~s;
        q();
        scl = 1'b1;
        q();
        sda_low = s;
        q();
        scl = ~s;
        q();
    endtask
    // Data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        q();
        scl = 1'b1;
        q();
        q();
        r = sda;
        scl = 1'b0;
        q();
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], ack);
        end
        bit_io(1'b1, ack);
    endtask
    task automatic recv(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask
endmodule // tweep_master

/* tb/test_tweep_slave.sv */
// Self-checking bench for the two-wire EEPROM slave
`include "tweep_defines.svh"
module test_tweep_slave;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WRC = 400;
    typedef struct packed {logic [15:0] a; logic [7:0] d;} tweep_row_t;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       wp = 1'b0;
    logic [2:0] sel = 3'b101;
    logic       scl, sda, sda_o, sda_oe, busy, m_low, ack;
    logic [7:0] d;
    logic [7:0] mem [logic [13:0]];
    int         n_errors = 0;
    int         comparisons = 0;
    int         cyc = 0;
    tweep_row_t rows [5] = '{'{16'h0000, 8'h5a}, '{16'hc123, 8'ha7}, '{16'h3fff, 8'h3c}, '{16'h0001, 8'h96},
                             '{16'h1fc0, 8'hff}};
    // Open drain with pull-up
    assign sda = ~(sda_oe | m_low);
    always #2 clk = ~clk;
    tweep_slave #(.WR_CYCLES(WRC)) dut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .select_pin_high(sel[2]), .select_pin_mid(sel[1]), .select_pin_low(sel[0]),
        .wp_i(wp), .prog_busy(busy));
    tweep_master mst (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Run is about 43k cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic dev(input logic [7:0] w, input logic e);
        mst.cond(1'b1);
        mst.send(w, ack);
        chk("dev_ack", 8'(ack), 8'(e));
        chk("sda_o", 8'(sda_o), 8'h00);
    endtask
    task automatic setup(input logic [15:0] a);
        dev({`TWE_DEV_TYPE, sel, 1'b0}, 1'b0);
        mst.send(a[15:8], ack);
        chk("hi_ack", 8'(ack), 8'h00);
        mst.send(a[7:0], ack);
        chk("lo_ack", 8'(ack), 8'h00);
    endtask
    task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d0);
        setup(a);
        for (int k = 0; k < n; k++) begin
            mst.send(d0 + 8'(k), ack);
            chk("data_ack", 8'(ack), 8'h00);
            if (!wp) mem[{a[13:6], 6'(a[5:0] + k)}] = d0 + 8'(k);
        end
        mst.cond(1'b0);
        repeat (4) @(negedge clk);
        chk("prog_busy", 8'(busy), 8'(n > 0 && !wp));
    endtask
    task automatic settle();
        int n = 0;
        while (busy === 1'b1 && n <= WRC) begin
            n++;
            @(negedge clk);
        end
        chk("prog_len_ok", 8'(n <= WRC), 8'h01);
        chk("busy_end", 8'(busy), 8'h00);
    endtask
    task automatic rd(input logic [13:0] a, input int n);
        dev({`TWE_DEV_TYPE, sel, 1'b1}, 1'b0);
        for (int k = 0; k < n; k++) begin
            mst.recv(k == n - 1, d);
            chk("rd_data", d, mem[14'(a + k)]);
        end
        mst.cond(1'b0);
    endtask
    initial begin
        repeat (2) @(negedge clk);
        chk("oe_rst", 8'(sda_oe), 8'h00);
        chk("busy_rst", 8'(busy), 8'h00);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        foreach (rows[i]) begin
            wr(rows[i].a, 1, rows[i].d);
            settle();
            setup(rows[i].a);
            rd(rows[i].a[13:0], 1);
        end
        dev({4'hb, sel, 1'b0}, 1'b1);
        mst.cond(1'b0);
        for (int i = 0; i < 3; i++) begin
            dev({`TWE_DEV_TYPE, sel ^ 3'(1 << i), 1'b1}, 1'b1);
            mst.cond(1'b0);
        end
        wr(16'h0478, 66, 8'h00);
        // Polling while programming gets no ack
        dev({`TWE_DEV_TYPE, sel, 1'b0}, 1'b1);
        mst.cond(1'b0);
        settle();
        rd(14'h047a, 6);
        setup(16'h0440);
        rd(14'h0440, 64);
        wp = 1'b1;
        wr(16'h0000, 1, 8'h11);
        wp = 1'b0;
        setup(16'h3fff);
        rd(14'h3fff, 2);
        rd(14'h0001, 1);
        // Dummy write starts no program cycle
        wr(16'h1fc0, 0, 8'h00);
        rd(14'h1fc0, 1);
        // Straps moved: the old address is refused, the new one answers
        sel = 3'b010;
        repeat (4) @(negedge clk);
        dev({`TWE_DEV_TYPE, 3'b101, 1'b1}, 1'b1);
        mst.cond(1'b0);
        setup(16'h0001);
        rd(14'h0001, 1);
        // Mid-run reset while idle clears the counter
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk("oe_rst2", 8'(sda_oe), 8'h00);
        chk("busy_rst2", 8'(busy), 8'h00);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        rd(14'h0000, 1);
        close_out();
    end
endmodule // test_tweep_slave
